/* touch_key_pkg.sv */
// Constants and types shared by the touch key module files
package touch_key_pkg;

  // ****************************************
  // Register word offsets on the bus
  // ****************************************
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h00;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFS_MUX_CTL = 8'h08;
  localparam logic [7:0] OFS_PIN_CTL = 8'h0c;
  localparam logic [7:0] OFS_MEAS_CTL = 8'h10;
  localparam logic [7:0] OFS_WIN_CTL = 8'h14;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_MUX_CTL = 8'h00;
  localparam logic [7:0] RST_PIN_CTL = 8'h00;
  localparam logic [7:0] RST_MEAS_CTL = 8'h00;
  localparam logic [7:0] RST_WIN_CTL = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int KEY_SELECT_LO = 6;
  localparam int SELECTOR_EN_LO = 4;
  localparam int SENSE_COUNTER_ENABLE = 7;
  localparam int MEASURE_START = 5;
  localparam int REF_CLOCK_ENABLE = 4;
  localparam int SLOT_COUNTER_CLEAR = 3;
  localparam int SENSE_COUNTER_CLEAR = 2;
  localparam int SLOT_CLOCK_SOURCE = 0;
  localparam int SLOT_OVERFLOW_FLAG = 5;
  localparam int SENSE_OVERFLOW_FLAG = 4;
  localparam int WIN_RESERVED = 3;

  // ****************************************
  // Counter sizes
  // ****************************************
  localparam int SENSE_W = 16;
  localparam int SLOT_W = 13;
  localparam logic [13:0] SLOT_BASE_COUNT = 14'h0040;

  // ****************************************
  // Measurement states
  // ****************************************
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_MEASURE = 2'b10
  } meas_state_type;

endpackage : touch_key_pkg

/* osc_edge_detect.sv */
// Rising edge detector for an oscillator level sampled on the clock
`timescale 1ns/1ps
module osc_edge_detect
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Oscillator level and its rising edge pulse
  input wire logic level,
  output logic rise
);
  import touch_key_pkg::*;

  typedef struct packed
  {
    logic prev_r;
  } edge_type;

  edge_type st_r;
  edge_type st_nxt;

  always_comb
  begin
    st_nxt.prev_r = level;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rise = level & ~st_r.prev_r;

endmodule : osc_edge_detect

/* tick_counter.sv */
// Up counter with clear and tick enable, wrapping at its full width
`timescale 1ns/1ps
module tick_counter #(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic clear,
  input wire logic tick,
  // State
  output logic [WIDTH-1:0] count,
  output logic wrap
);
  import touch_key_pkg::*;

  typedef struct packed
  {
    logic [WIDTH-1:0] count_r;
  } cnt_type;

  cnt_type st_r;
  cnt_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    // Clear wins over a tick in the same cycle
    if (clear)
    begin
      st_nxt.count_r = '0;
    end
    else if (tick)
    begin
      st_nxt.count_r = st_r.count_r + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.count_r;
  assign wrap = tick & ~clear & (&st_r.count_r);

endmodule : tick_counter

/* touch_key_module.sv */
// One capacitive touch key module with its Wishbone register file
// What this block does
// - Count readable as two bytes, reset zero
// - Two-bit field selects one of four keys
// - Selector enable bits disable or enable keys
// - Pin bits hand pins to touch function
// - Top measure bit gates the sense counter
// - Start bit rising edge starts slot counting
// - Slot count end raises touch key interrupt
// - Reference clock enable bit gates reference
// - Slot clear bit resets slot counter
// - Sense clear bit resets sense counter
// - Slot clock from reference or key four
// - Read-only slot overflow flag after overflow
// - Writable sense overflow flag, zero until wrap
// - Window length code gives 64 to 8192
// - Top status bits read-only, read as zero
// - Count sense cycles over a reference window
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module touch_key_module
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Oscillators
  input wire logic ref_clk_in,
  input wire logic [3:0] key_osc_in,
  output logic ref_osc_en,
  output logic [3:0] key_osc_en,
  // Pin function select
  output logic [3:0] pin_touch_sel,
  // Requests to the interrupt controller
  output logic slot_irq,
  output logic sense_irq
);
  import touch_key_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed
  {
    meas_state_type state;
    logic [7:0] mux_ctl;
    logic [7:0] pin_ctl;
    logic [7:0] meas_ctl;
    logic [3:0] win_ctl;
    logic slot_ovf;
    logic sense_ovf;
    logic ack;
    logic [7:0] rd_data;
    logic slot_irq;
    logic sense_irq;
  } ctl_type;

  ctl_type st_r;
  ctl_type st_nxt;

  logic [1:0] key_select;
  logic sense_level;
  logic sense_rise;
  logic key4_rise;
  logic ref_rise;
  logic sense_tick;
  logic slot_tick;
  logic slot_done;
  logic slot_clear;
  logic sense_clear;
  logic sense_wrap;
  logic [SENSE_W-1:0] sense_count;
  logic [SLOT_W-1:0] slot_count;
  logic [13:0] slot_term;
  logic [SLOT_W-1:0] slot_last;
  logic bus_req;
  logic bus_wr;
  logic start_rise;

  // ****************************************
  // Key routing
  // ****************************************
  assign key_select = st_r.mux_ctl[KEY_SELECT_LO +: 2];
  assign key_osc_en = st_r.pin_ctl[SELECTOR_EN_LO +: 4];
  assign pin_touch_sel = st_r.pin_ctl[3:0];
  assign ref_osc_en = st_r.meas_ctl[REF_CLOCK_ENABLE];
  // A key reaches the counter only if enabled and owning its pin
  assign sense_level = key_osc_in[key_select] & key_osc_en[key_select]
    & pin_touch_sel[key_select];

  osc_edge_detect sense_edge
  (
    .clk(clk),
    .reset_n(reset_n),
    .level(sense_level),
    .rise(sense_rise)
  );

  osc_edge_detect key4_edge
  (
    .clk(clk),
    .reset_n(reset_n),
    .level(key_osc_in[3] & key_osc_en[3] & pin_touch_sel[3]),
    .rise(key4_rise)
  );

  osc_edge_detect ref_edge
  (
    .clk(clk),
    .reset_n(reset_n),
    .level(ref_clk_in & ref_osc_en),
    .rise(ref_rise)
  );

  // ****************************************
  // Counters
  // ****************************************
  // Sense cycles counted only inside the reference window
  assign sense_tick = sense_rise & st_r.meas_ctl[SENSE_COUNTER_ENABLE]
    & (st_r.state == ST_MEASURE);
  assign sense_clear = st_r.meas_ctl[SENSE_COUNTER_CLEAR];
  assign slot_tick = (st_r.state == ST_MEASURE) &
    (st_r.meas_ctl[SLOT_CLOCK_SOURCE] ? key4_rise : ref_rise);
  assign slot_term = SLOT_BASE_COUNT << st_r.win_ctl[2:0];
  assign slot_last = SLOT_W'(slot_term - 14'h0001);
  assign slot_done = slot_tick & (slot_count == slot_last);
  assign slot_clear = st_r.meas_ctl[SLOT_COUNTER_CLEAR] | start_rise
    | slot_done;

  tick_counter #(.WIDTH(SENSE_W)) sense_counter
  (
    .clk(clk),
    .reset_n(reset_n),
    .clear(sense_clear),
    .tick(sense_tick),
    .count(sense_count),
    .wrap(sense_wrap)
  );

  tick_counter #(.WIDTH(SLOT_W)) slot_counter
  (
    .clk(clk),
    .reset_n(reset_n),
    .clear(slot_clear),
    .tick(slot_tick),
    .count(slot_count),
    .wrap()
  );

  // ****************************************
  // Bus decode and control
  // ****************************************
  assign bus_req = cyc_i & stb_i & ~st_r.ack;
  assign bus_wr = bus_req & we_i & sel_i[0];
  assign start_rise = bus_wr & (adr_i == OFS_MEAS_CTL)
    & dat_i[MEASURE_START] & ~st_r.meas_ctl[MEASURE_START];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = bus_req;
    st_nxt.slot_irq = 1'b0;
    st_nxt.sense_irq = 1'b0;
    // Writes land at the request edge; unmapped offsets are ignored
    if (bus_wr)
    begin
      if (adr_i == OFS_MUX_CTL)
      begin
        st_nxt.mux_ctl = dat_i[7:0];
      end
      else if (adr_i == OFS_PIN_CTL)
      begin
        st_nxt.pin_ctl = dat_i[7:0];
      end
      else if (adr_i == OFS_MEAS_CTL)
      begin
        st_nxt.meas_ctl = dat_i[7:0];
      end
      else if (adr_i == OFS_WIN_CTL)
      begin
        st_nxt.win_ctl = dat_i[3:0];
        st_nxt.sense_ovf = dat_i[SENSE_OVERFLOW_FLAG];
      end
    end
    // Reads show live state; top status bits read as zero
    st_nxt.rd_data = 8'h00;
    if (bus_req & ~we_i)
    begin
      if (adr_i == OFS_COUNT_HIGH)
      begin
        st_nxt.rd_data = sense_count[15:8];
      end
      else if (adr_i == OFS_COUNT_LOW)
      begin
        st_nxt.rd_data = sense_count[7:0];
      end
      else if (adr_i == OFS_MUX_CTL)
      begin
        st_nxt.rd_data = st_r.mux_ctl;
      end
      else if (adr_i == OFS_PIN_CTL)
      begin
        st_nxt.rd_data = st_r.pin_ctl;
      end
      else if (adr_i == OFS_MEAS_CTL)
      begin
        st_nxt.rd_data = st_r.meas_ctl;
      end
      else if (adr_i == OFS_WIN_CTL)
      begin
        st_nxt.rd_data = {2'b00, st_r.slot_ovf, st_r.sense_ovf,
          st_r.win_ctl};
      end
    end
    // Window sequencing
    case (st_r.state)
      ST_IDLE:
      begin
        if (start_rise)
        begin
          st_nxt.state = ST_MEASURE;
          st_nxt.slot_ovf = 1'b0;
        end
      end
      ST_MEASURE:
      begin
        if (!st_nxt.meas_ctl[MEASURE_START])
        begin
          st_nxt.state = ST_IDLE;
        end
        else if (slot_done)
        begin
          st_nxt.state = ST_IDLE;
          st_nxt.slot_ovf = 1'b1;
          st_nxt.slot_irq = 1'b1;
        end
      end
      default:
      begin
        st_nxt.state = ST_IDLE;
      end
    endcase
    // Hardware set beats a software clear in the same cycle
    if (sense_wrap)
    begin
      st_nxt.sense_ovf = 1'b1;
      st_nxt.sense_irq = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
      st_r.mux_ctl <= RST_MUX_CTL;
      st_r.pin_ctl <= RST_PIN_CTL;
      st_r.meas_ctl <= RST_MEAS_CTL;
      st_r.win_ctl <= RST_WIN_CTL[3:0];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign dat_o = {24'h000000, st_r.rd_data};
  assign ack_o = st_r.ack;
  assign slot_irq = st_r.slot_irq;
  assign sense_irq = st_r.sense_irq;

  // ****************************************
  // Checks
  // ****************************************
  logic [13:0] ticks_seen_r;

  always_ff @(posedge clk)
  begin
    if (!reset_n || start_rise)
    begin
      ticks_seen_r <= 14'h0000;
    end
    else if (slot_tick && !st_r.meas_ctl[SLOT_COUNTER_CLEAR])
    begin
      ticks_seen_r <= ticks_seen_r + 14'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sense_clear_a: assert property (
    sense_clear |=> sense_count == '0)
    else $error("sense counter not cleared");
  slot_clear_a: assert property (
    st_r.meas_ctl[SLOT_COUNTER_CLEAR] |=> slot_count == '0)
    else $error("slot counter not cleared");
  key_disable_a: assert property (
    !key_osc_en[key_select] && !sense_clear
    |=> sense_count == $past(sense_count))
    else $error("disabled key was counted");
  count_gate_a: assert property (
    !st_r.meas_ctl[SENSE_COUNTER_ENABLE] && !sense_clear
    |=> $stable(sense_count))
    else $error("sense counter ran while gated off");
  pin_route_a: assert property (
    !pin_touch_sel[key_select] |-> !sense_tick)
    else $error("io pin fed the sense counter");
  // A start edge clears the slot count, so it is left out here
  start_stop_a: assert property (
    !st_r.meas_ctl[MEASURE_START] && !st_r.meas_ctl[SLOT_COUNTER_CLEAR]
    && !start_rise |=> $stable(slot_count))
    else $error("slot counter ran while stopped");
  window_end_a: assert property (
    slot_done && st_r.meas_ctl[MEASURE_START]
    |=> slot_irq && st_r.slot_ovf && st_r.state == ST_IDLE ##1 !slot_irq)
    else $error("window end not signalled");
  window_len_a: assert property (
    slot_irq && !$past(start_rise) |-> ticks_seen_r == $past(slot_term))
    else $error("window length wrong");
  ref_gate_a: assert property (
    !st_r.meas_ctl[SLOT_CLOCK_SOURCE] && !ref_osc_en && !slot_clear
    ##1 !slot_clear |=> $stable(slot_count))
    else $error("slot counted with reference off");
  wrap_flag_a: assert property (
    sense_wrap |=> st_r.sense_ovf && sense_irq && sense_count == '0)
    else $error("sense wrap lost");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");

  window_done_c: cover property (slot_irq);
  sense_wrap_c: cover property (sense_wrap);
  start_c: cover property (start_rise ##[1:100] slot_tick);

endmodule : touch_key_module

/* touch_pad_model.sv */
// Behavioural touch pads and reference oscillator at the module's far side
`timescale 1ns/1ps
module touch_pad_model
(
  // Clock
  input wire logic clk,
  // Enables from the module
  input wire logic ref_osc_en,
  input wire logic [3:0] key_osc_en,
  input wire logic [3:0] pin_touch_sel,
  // Slow pads, as a finger on every pad would give
  input wire logic slow,
  // Oscillator levels
  output logic ref_clk_in,
  output logic [3:0] key_osc_in
);
  // Half periods in clocks
  int half [4] = '{2, 4, 8, 1};
  int cnt [4] = '{0, 0, 0, 0};

  initial ref_clk_in = 1'b0;
  initial key_osc_in = 4'h0;

  // A stopped oscillator sits low, so no stray edge follows a disable
  always @(posedge clk)
  begin
    ref_clk_in <= ref_osc_en ? ~ref_clk_in : 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      if (!(key_osc_en[k] && pin_touch_sel[k]))
      begin
        cnt[k] <= 0;
        key_osc_in[k] <= 1'b0;
      end
      else if (cnt[k] + 1 >= half[k] * (slow ? 2 : 1))
      begin
        cnt[k] <= 0;
        key_osc_in[k] <= ~key_osc_in[k];
      end
      else
        cnt[k] <= cnt[k] + 1;
    end
  end
endmodule : touch_pad_model

/* testbench.sv */
// Self-checking bench for the touch key module
`timescale 1ns/1ps
module testbench;
  import touch_key_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic ref_clk;
  logic [3:0] key_osc;
  logic ref_en;
  logic [3:0] key_en;
  logic [3:0] touch_sel;
  logic slot_irq;
  logic sense_irq;
  logic slow = 1'b0;
  logic [7:0] rd;
  logic [15:0] c;
  int errors = 0;
  int checks = 0;
  int n;
  int per [4] = '{32, 16, 8, 64};

  always #4 clk = ~clk;

  touch_key_module DUT (.clk(clk), .reset_n(reset_n), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .ref_clk_in(ref_clk), .key_osc_in(key_osc),
    .ref_osc_en(ref_en), .key_osc_en(key_en), .pin_touch_sel(touch_sel),
    .slot_irq(slot_irq), .sense_irq(sense_irq));

  touch_pad_model pads (.clk(clk), .ref_osc_en(ref_en),
    .key_osc_en(key_en), .pin_touch_sel(touch_sel), .slow(slow),
    .ref_clk_in(ref_clk), .key_osc_in(key_osc));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tally_and_finish;
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic fail(input string msg);
    errors++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  function automatic bit bad(input bit ok);
    checks++;
    return !ok;
  endfunction : bad

  // Master waits as long as the slave likes, up to the bench bound
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    if (i == 20)
    begin
      fail("bus timeout");
      tally_and_finish;
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wait_irq(input int lim);
    for (n = 1; n <= lim; n++)
    begin
      @(posedge clk);
      if (slot_irq === 1'b1)
        break;
    end
  endtask : wait_irq

  task automatic run(input logic [7:0] c2, input int lim);
    wb(OFS_MEAS_CTL, 1'b1, 8'h0c);
    wb(OFS_MEAS_CTL, 1'b1, c2);
    wb(OFS_MEAS_CTL, 1'b1, c2 | 8'h20);
    wait_irq(lim);
    wb(OFS_MEAS_CTL, 1'b1, c2);
  endtask : run

  task automatic count;
    wb(OFS_COUNT_HIGH, 1'b0, 8'h00);
    c[15:8] = rd;
    wb(OFS_COUNT_LOW, 1'b0, 8'h00);
    c[7:0] = rd;
  endtask : count

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] ofs [6] = '{OFS_COUNT_HIGH, OFS_COUNT_LOW, OFS_MUX_CTL,
      OFS_PIN_CTL, OFS_MEAS_CTL, OFS_WIN_CTL};
    for (int i = 0; i < 6; i++)
    begin
      wb(ofs[i], 1'b0, 8'h00);
      if (bad(rd === 8'h00)) fail("reset value");
    end
    wb(8'h18, 1'b1, 8'hff);
    wb(8'h18, 1'b0, 8'h00);
    if (bad(rd === 8'h00)) fail("unmapped read");
  endtask : t_reset

  task automatic t_regs;
    wb(OFS_MUX_CTL, 1'b1, 8'hd8);
    wb(OFS_MUX_CTL, 1'b0, 8'h00);
    if (bad(rd === 8'hd8)) fail("key select readback");
    wb(OFS_PIN_CTL, 1'b1, 8'ha5);
    if (bad(key_en === 4'ha)) fail("selector enables");
    if (bad(touch_sel === 4'h5)) fail("pin select");
    // Reserved bit three is left at its reset value
    wb(OFS_WIN_CTL, 1'b1, 8'hf7);
    wb(OFS_WIN_CTL, 1'b0, 8'h00);
    if (bad((rd & 8'h3f) === 8'h17)) fail("status access");
    wb(OFS_WIN_CTL, 1'b1, 8'h00);
    wb(OFS_WIN_CTL, 1'b0, 8'h00);
    if (bad(rd[4] === 1'b0)) fail("sense flag write");
    wb(OFS_MEAS_CTL, 1'b1, 8'h10);
    if (bad(ref_en === 1'b1)) fail("ref enable on");
    wb(OFS_MEAS_CTL, 1'b1, 8'h00);
    if (bad(ref_en === 1'b0)) fail("ref enable off");
  endtask : t_regs

  task automatic t_window;
    wb(OFS_PIN_CTL, 1'b1, 8'hff);
    for (int code = 0; code < 8; code++)
    begin
      wb(OFS_WIN_CTL, 1'b1, code[7:0]);
      run(8'h10, (128 << code) + 40);
      if (bad(n + 4 >= 128 << code && n <= (128 << code) + 4))
        fail("window length");
      wb(OFS_WIN_CTL, 1'b0, 8'h00);
      if (bad(rd[5] === 1'b1)) fail("slot overflow flag");
    end
    wb(OFS_WIN_CTL, 1'b1, 8'h00);
  endtask : t_window

  task automatic t_sense;
    for (int k = 0; k < 4; k++)
    begin
      wb(OFS_MUX_CTL, 1'b1, {k[1:0], 6'h18});
      run(8'h90, 300);
      count;
      if (bad(c + 2 >= per[k] && c <= per[k] + 2))
        fail("sense count");
    end
    wb(OFS_WIN_CTL, 1'b0, 8'h00);
    if (bad(rd[4] === 1'b0)) fail("sense flag set early");
    wb(OFS_MUX_CTL, 1'b1, 8'h18);
    // Pad model samples this on the clock, so drive it off the race
    slow <= 1'b1;
    run(8'h90, 300);
    count;
    slow <= 1'b0;
    if (bad(c + 2 >= 16 && c <= 18)) fail("slow pad count");
    run(8'h10, 300);
    count;
    if (bad(c === 16'h0000)) fail("counter not gated");
    wb(OFS_PIN_CTL, 1'b1, 8'hef);
    run(8'h90, 300);
    count;
    if (bad(c === 16'h0000)) fail("disabled key counted");
    wb(OFS_PIN_CTL, 1'b1, 8'hfe);
    run(8'h90, 300);
    count;
    if (bad(c === 16'h0000)) fail("io pin counted");
    wb(OFS_PIN_CTL, 1'b1, 8'hff);
    run(8'h90, 300);
    wb(OFS_MEAS_CTL, 1'b1, 8'h04);
    wb(OFS_MEAS_CTL, 1'b1, 8'h00);
    count;
    if (bad(c === 16'h0000)) fail("sense clear");
  endtask : t_sense

  // Ends on a finished window so the overflow flag is left set
  task automatic t_source;
    run(8'h00, 400);
    if (bad(n == 401)) fail("slot ran without ref");
    run(8'h01, 300);
    if (bad(n >= 124 && n <= 132)) fail("key four slot clock");
  endtask : t_source

  task automatic t_abort;
    wb(OFS_MEAS_CTL, 1'b1, 8'h10);
    wb(OFS_MEAS_CTL, 1'b1, 8'h30);
    wb(OFS_WIN_CTL, 1'b0, 8'h00);
    if (bad(rd[5] === 1'b0)) fail("flag not cleared");
    wb(OFS_MEAS_CTL, 1'b1, 8'h10);
    wait_irq(300);
    if (bad(n == 301)) fail("aborted window fired");
    wb(OFS_MEAS_CTL, 1'b1, 8'h18);
    wb(OFS_MEAS_CTL, 1'b1, 8'h38);
    wait_irq(300);
    if (bad(n == 301)) fail("slot clear ignored");
    wb(OFS_MEAS_CTL, 1'b1, 8'h00);
  endtask : t_abort

  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_regs;
    t_window;
    t_sense;
    t_source;
    t_abort;
    tally_and_finish;
  end
endmodule : testbench
